// file: rtl/boot_seq_pkg.sv
// constants for the array boot and reconfiguration sequencer
// assumes a 200 MHz array clock and a 32-bit avalon-mm register port
package boot_seq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TILE_N = 8;
  // register byte offsets
  localparam logic [7:0] OFS_PLL_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SECURE = 8'h0C;
  localparam logic [7:0] OFS_TILE_RST = 8'h10;
  localparam logic [7:0] OFS_SOFT_RST = 8'h14;
  localparam logic [7:0] OFS_CFG_BASE = 8'h40;
  localparam int CFG_WORDS = 16;
  // control register fields
  localparam int CTRL_PLL_EN = 0;
  localparam int CTRL_GRST_REL = 1;
  localparam int CTRL_FABRIC_EN = 2;
  // status register fields
  localparam int ST_CFG_DONE = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_GRST = 2;
  localparam int ST_STATE_LSB = 4;
  // reset values
  localparam logic [15:0] PLL_CFG_RST = 16'h0001;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  localparam logic [31:0] SOFT_RST_KEY = 32'h0000_0001;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int LOCK_TIME_US = 50;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam int SOFT_RST_CYCLES = 16;
  typedef enum logic [2:0] {
    ST_POR, ST_CONFIG, ST_LOCKING, ST_HELD, ST_RUN
  } state_type;
endpackage

// file: rtl/array_boot_reconfig_sequencer.sv
// boot, reset and reconfiguration sequencing for the tiled array
// assumes the platform manager drives the register port and holds por
`timescale 1ns/1ps
// Behaviour
// - pll runs default frequency before programming
// - pll enable only after config; starts pll
// - enabled pll settles then raises lock
// - global reset released after lock by write
// - global registers decoded in config space
// - any network master writes any register except status; pll config only before pll enable
// - configuration is image words into registers
// - reconfiguration accepted any time after boot
// - full reconfiguration leaves global reset to software; config writes do not assert it
// - untouched tiles keep running during partial
// - soft reset register write of SOFT_RST_KEY resets array
module array_boot_reconfig_sequencer
  #(parameter int LOCK_CYCLES_P = boot_seq_pkg::LOCK_CYCLES) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // power-up reset from platform manager, active low
  input wire logic por_n_in,
  // avalon-mm register slave
  input wire logic [boot_seq_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [boot_seq_pkg::DATA_W-1:0] avs_writedata_in,
  output logic [boot_seq_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // pll side
  output logic [15:0] pll_cfg_out,
  output logic pll_en_out,
  output logic pll_lock_out,
  // array side
  output logic global_rst_out,
  output logic [boot_seq_pkg::TILE_N-1:0] tile_rst_out,
  output logic [boot_seq_pkg::TILE_N-1:0] tile_run_out,
  output logic fabric_if_en_out,
  output logic [31:0] secure_out,
  output logic cfg_we_out,
  output logic [3:0] cfg_addr_out,
  output logic [31:0] cfg_data_out
);
  import boot_seq_pkg::*;

  localparam int LCW = $clog2(LOCK_CYCLES_P + 1);

  // pin input synchroniser, three stages
  logic por_s1_q;
  logic por_s2_q;
  logic por_s3_q;
  logic por_q;
  always_ff @(posedge clk_in) begin
    por_s1_q <= por_n_in;
    por_s2_q <= por_s1_q;
    por_s3_q <= por_s2_q;
  end
  wire por_agree = (por_s2_q == por_s3_q);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      por_q <= 1'b0;
    end else if (por_agree) begin
      por_q <= por_s3_q;
    end
  end
  wire in_por = rst_in | ~por_q;

  state_type state_q, state_d;
  logic [15:0] pll_cfg_q;
  logic cfg_done_q;
  logic pll_en_q;
  logic grst_q;
  logic lock_q;
  logic fabric_q;
  logic [LCW-1:0] lock_cnt_q;
  logic [31:0] secure_q;
  logic [TILE_N-1:0] tile_rst_q;
  logic [4:0] soft_cnt_q;
  logic [31:0] cfg_mem [CFG_WORDS];
  logic ack_q;
  logic [31:0] rdata_q;
  logic cfg_we_q;
  logic [3:0] cfg_addr_q;
  logic [31:0] cfg_data_q;

  // one wait cycle per access, then answer
  wire req = (avs_read_in | avs_write_in) & ~ack_q;
  wire wr = avs_write_in & ack_q;
  wire rd = avs_read_in & ack_q;
  wire hit_pll = (avs_address_in == OFS_PLL_CFG);
  wire hit_ctrl = (avs_address_in == OFS_CTRL);
  wire hit_stat = (avs_address_in == OFS_STATUS);
  wire hit_sec = (avs_address_in == OFS_SECURE);
  wire hit_tile = (avs_address_in == OFS_TILE_RST);
  wire hit_soft = (avs_address_in == OFS_SOFT_RST);
  wire hit_cfg = (avs_address_in[7:6] == OFS_CFG_BASE[7:6])
    & (avs_address_in[1:0] == 2'b00);
  wire [3:0] cfg_idx = avs_address_in[5:2];

  wire pll_en_wr = wr & hit_ctrl & avs_writedata_in[CTRL_PLL_EN]
    & cfg_done_q;
  wire grst_rel_wr = wr & hit_ctrl & avs_writedata_in[CTRL_GRST_REL]
    & lock_q;
  wire grst_set_wr = wr & hit_ctrl & ~avs_writedata_in[CTRL_GRST_REL];
  wire soft_wr = wr & hit_soft & (avs_writedata_in == SOFT_RST_KEY);
  wire soft_active = (soft_cnt_q != 5'd0);
  wire lock_done = (lock_cnt_q == LCW'(LOCK_CYCLES_P));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POR: state_d = ST_CONFIG;
      ST_CONFIG: begin
        if (pll_en_wr) begin
          state_d = ST_LOCKING;
        end
      end
      ST_LOCKING: begin
        if (lock_done) begin
          state_d = ST_HELD;
        end
      end
      ST_HELD: begin
        if (grst_rel_wr) begin
          state_d = ST_RUN;
        end
      end
      // a soft reset drops back to held, so software must release again
      ST_RUN: begin
        if (grst_set_wr | soft_wr) begin
          state_d = ST_HELD;
        end
      end
      default: state_d = ST_POR;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (in_por) begin
      state_q <= ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (in_por) begin
      pll_cfg_q <= PLL_CFG_RST;
      cfg_done_q <= 1'b0;
      secure_q <= 32'h0000_0000;
    end else if (wr & hit_pll & ~pll_en_q) begin
      pll_cfg_q <= avs_writedata_in[15:0];
      cfg_done_q <= 1'b1;
    end else if (wr & hit_sec) begin
      secure_q <= avs_writedata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (in_por) begin
      pll_en_q <= 1'b0;
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end else begin
      if (pll_en_wr) begin
        pll_en_q <= 1'b1;
      end
      // counter parks at the end value, lock then stays up
      if (pll_en_q & ~lock_done) begin
        lock_cnt_q <= lock_cnt_q + LCW'(1);
      end
      lock_q <= pll_en_q & lock_done;
    end
  end

  always_ff @(posedge clk_in) begin
    if (in_por) begin
      grst_q <= 1'b1;
    end else begin
      grst_q <= (state_d != ST_RUN);
    end
  end

  always_ff @(posedge clk_in) begin
    if (in_por) begin
      soft_cnt_q <= 5'd0;
    end else if (soft_wr) begin
      soft_cnt_q <= 5'(SOFT_RST_CYCLES);
    end else if (soft_active) begin
      soft_cnt_q <= soft_cnt_q - 5'd1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (in_por) begin
      tile_rst_q <= '0;
      fabric_q <= 1'b0;
    end else begin
      if (wr & hit_tile) begin
        tile_rst_q <= avs_writedata_in[TILE_N-1:0];
      end
      if (wr & hit_ctrl) begin
        fabric_q <= avs_writedata_in[CTRL_FABRIC_EN];
      end
    end
  end

  // accepted in any state after boot
  always_ff @(posedge clk_in) begin
    if (wr & hit_cfg) begin
      cfg_mem[cfg_idx] <= avs_writedata_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (in_por) begin
      cfg_we_q <= 1'b0;
      cfg_addr_q <= 4'h0;
      cfg_data_q <= 32'h0000_0000;
    end else begin
      cfg_we_q <= wr & hit_cfg;
      if (wr & hit_cfg) begin
        cfg_addr_q <= cfg_idx;
        cfg_data_q <= avs_writedata_in;
      end
    end
  end

  wire [31:0] ctrl_rd = {29'h0, fabric_q, ~grst_q, pll_en_q};
  wire [31:0] stat_rd = {25'h0, state_q, 1'b0, grst_q, lock_q,
    cfg_done_q};
  wire [31:0] rd_mux =
    hit_pll ? {16'h0000, pll_cfg_q} :
    hit_ctrl ? ctrl_rd :
    hit_stat ? stat_rd :
    hit_sec ? secure_q :
    hit_tile ? {{(32-TILE_N){1'b0}}, tile_rst_q} :
    hit_cfg ? cfg_mem[cfg_idx] : UNMAPPED_RD;

  // data registered on the request's first cycle, shown on the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (avs_read_in & ~ack_q) rdata_q <= rd_mux;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out = rdata_q;
  assign pll_cfg_out = pll_cfg_q;
  assign pll_en_out = pll_en_q;
  assign pll_lock_out = lock_q;
  // soft reset also idles the whole array, a trade against a second fsm
  assign global_rst_out = grst_q | soft_active;
  assign tile_rst_out = tile_rst_q | {TILE_N{global_rst_out}};
  assign tile_run_out = ~tile_rst_out;
  assign fabric_if_en_out = fabric_q & ~global_rst_out;
  assign secure_out = secure_q;
  assign cfg_we_out = cfg_we_q;
  assign cfg_addr_out = cfg_addr_q;
  assign cfg_data_out = cfg_data_q;
  wire unused_rd = rd;
endmodule

// file: verification/seq_chk.sv
// port checker for the boot and reconfiguration sequencer
// bound to every sequencer instance, one clock domain
`timescale 1ns/1ps
module seq_chk
  import boot_seq_pkg::*;
  #(parameter int LOCK_CYCLES_P = 20) (
  // watched ports
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic [15:0] pll_cfg_out,
  input wire logic pll_en_out,
  input wire logic pll_lock_out,
  input wire logic global_rst_out,
  input wire logic [7:0] tile_rst_out,
  input wire logic [7:0] tile_run_out,
  input wire logic fabric_if_en_out,
  input wire logic cfg_we_out,
  input wire logic [3:0] cfg_addr_out,
  input wire logic [31:0] cfg_data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_acc;
    avs_write_in && !avs_waitrequest_out;
  endsequence
  property p_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
  property p_dflt;
    $fell(rst_in) |-> pll_cfg_out == PLL_CFG_RST;
  endproperty
  a_dflt: assert property (p_dflt) else $error("pll default");
  property p_cfgh;
    pll_en_out && $past(pll_en_out) |-> $stable(pll_cfg_out);
  endproperty
  a_cfgh: assert property (p_cfgh) else $error("pll cfg moved");
  property p_lock;
    $rose(pll_en_out) |-> !pll_lock_out [*8];
  endproperty
  a_lock: assert property (p_lock) else $error("early lock");
  property p_len;
    pll_lock_out |-> pll_en_out;
  endproperty
  a_len: assert property (p_len) else $error("lock without en");
  property p_rel;
    $fell(global_rst_out) |-> pll_lock_out;
  endproperty
  a_rel: assert property (p_rel) else $error("release no lock");
  property p_idle;
    global_rst_out |-> tile_run_out == 8'h00 && !fabric_if_en_out;
  endproperty
  a_idle: assert property (p_idle) else $error("tiles busy");
  property p_tile;
    tile_run_out == ~tile_rst_out;
  endproperty
  a_tile: assert property (p_tile) else $error("tile run");
  property p_cfg;
    s_acc ##0 avs_address_in[7:6] == 2'b01 |=> cfg_we_out
      && {2'b01, cfg_addr_out, 2'b00} == $past(avs_address_in)
      && cfg_data_out == $past(avs_writedata_in);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg write");
  property p_soft;
    s_acc ##0 avs_address_in == OFS_SOFT_RST
      && avs_writedata_in == SOFT_RST_KEY |=> global_rst_out [*8];
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
endmodule
bind array_boot_reconfig_sequencer seq_chk
  #(.LOCK_CYCLES_P(LOCK_CYCLES_P)) seq_chk_i (.*);

// file: verification/mgr_model.sv
// platform manager model: drives the power-up reset
// assumes bench clock and reset
`timescale 1ns/1ps
module mgr_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // power-up reset to array, active low
  output logic por_n_out
);
  int n;
  always_ff @(posedge clk_in) begin
    if (rst_in) n <= 0;
    else if (n < 12) n <= n + 1;
  end
  assign por_n_out = !rst_in && n >= 12;
endmodule

// file: verification/testbench.sv
// self-checking bench for the boot sequencer
// assumes the manager model drives power-up reset
`timescale 1ns/1ps
module testbench;
  import boot_seq_pkg::*;
  logic clk_in = 0, rst_in = 1, rd = 0, wr = 0, por_n, wreq, grst, fab;
  logic [7:0] addr = 8'h00, tile_run;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdat;
  int miscompares = 0, compares = 0;
  array_boot_reconfig_sequencer #(.LOCK_CYCLES_P(20))
    array_boot_reconfig_sequencer_i (.clk_in(clk_in), .rst_in(rst_in),
    .por_n_in(por_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .pll_cfg_out(), .pll_en_out(), .pll_lock_out(),
    .global_rst_out(grst), .tile_rst_out(), .tile_run_out(tile_run),
    .fabric_if_en_out(fab), .secure_out(), .cfg_we_out(),
    .cfg_addr_out(), .cfg_data_out());
  mgr_model mgr_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .por_n_out(por_n));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk_in); while (wreq !== 1'b0);
    rdat = rdata;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd32(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e);
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 0;
    repeat (25) @(posedge clk_in);
    rd32(OFS_PLL_CFG, 32'h0000_ffff, 32'h0000_0001);
    wr32(OFS_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk_in);
    rd32(OFS_STATUS, 32'h0000_0006, 32'h0000_0004);
    wr32(OFS_CTRL, 32'h0000_0002);
    rd32(OFS_STATUS, 32'h0000_0006, 32'h0000_0004);
    wr32(OFS_PLL_CFG, 32'h0000_0123);
    rd32(OFS_PLL_CFG, 32'h0000_ffff, 32'h0000_0123);
    wr32(OFS_SECURE, 32'h5a5a_c3c3);
    rd32(OFS_SECURE, 32'hffff_ffff, 32'h5a5a_c3c3);
    wr32(OFS_CTRL, 32'h0000_0001);
    repeat (25) @(posedge clk_in);
    rd32(OFS_STATUS, 32'h0000_0006, 32'h0000_0006);
    wr32(OFS_PLL_CFG, 32'h0000_0777);
    rd32(OFS_PLL_CFG, 32'h0000_ffff, 32'h0000_0123);
    wr32(OFS_CTRL, 32'h0000_0007);
    rd32(OFS_STATUS, 32'h0000_0006, 32'h0000_0002);
    chk({31'h0, fab}, 32'h0000_0001);
    $display("boot test done");
    wr32(OFS_TILE_RST, 32'h0000_000f);
    @(posedge clk_in);
    chk({24'h00_0000, tile_run}, 32'h0000_00f0);
    wr32(OFS_CTRL, 32'h0000_0003);
    @(posedge clk_in);
    chk({31'h0, fab}, 32'h0000_0000);
    wr32(OFS_CTRL, 32'h0000_0001);
    rd32(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    for (int i = 0; i < CFG_WORDS; i++)
      wr32(OFS_CFG_BASE + 8'(4 * i), 32'ha5a5_0000 + i);
    for (int i = 0; i < CFG_WORDS; i++)
      rd32(OFS_CFG_BASE + 8'(4 * i), '1, 32'ha5a5_0000 + i);
    rd32(8'h30, 32'hffff_ffff, UNMAPPED_RD);
    wr32(OFS_CTRL, 32'h0000_0007);
    rd32(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
    $display("config test done");
    wr32(OFS_SOFT_RST, 32'h0000_0002);
    rd32(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
    wr32(OFS_SOFT_RST, SOFT_RST_KEY);
    repeat (30) @(posedge clk_in);
    chk({31'h0, grst}, 32'h0000_0001);
    wr32(OFS_CTRL, 32'h0000_0007);
    rd32(OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
    $display("soft reset test done");
    final_report;
  end
endmodule
